/* host_port_pkg.sv */
package host_port_pkg;

    // ****************************************************************
    // Widths and register select codes
    // ****************************************************************
    localparam int unsigned ADDR_W       = 18;
    localparam int unsigned DATA_W       = 16;
    localparam logic [1:0]  SEL_CTRL     = 2'h0;
    localparam logic [1:0]  SEL_DATA_INC = 2'h1;
    localparam logic [1:0]  SEL_ADDR     = 2'h2;
    localparam logic [1:0]  SEL_DATA     = 2'h3;
    localparam int unsigned CTRL_IRQ_BIT = 3;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 18'h00001;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MEM,
        ST_HOLD
    } port_state_t;

    typedef struct packed {
        port_state_t       state;
        logic              strobe;
        logic              addr_strobe_n;
        logic              keeper_on;
        logic [ADDR_W-1:0] addr;
        logic              incr;
        logic [DATA_W-1:0] rdata;
        logic              data_oe;
        logic              keep_en;
        logic [DATA_W-1:0] keep_val;
        logic              irq;
        logic              irq_n;
        logic              ready;
        logic              mem_req;
        logic              mem_we;
        logic              mem_sub;
        logic [ADDR_W-1:0] mem_addr;
        logic [DATA_W-1:0] mem_wdata;
        logic              sub_reset_n;
    } port_regs_t;

endpackage

/* host_port_pin_interface.sv */
`timescale 1ns/1ps
`default_nettype none

// Contract
// - The shared pins act as the host port only while the function select input is low; the interrupt output is not gated by it.
// - In non-multiplexed mode the host's 18-line address bus addresses on-chip RAM directly.
// - A 16-line data bus carries words, driven by the host on writes and by the device on reads.
// - With keepers enabled and the device not driving, each data line holds its last driven level; the keeper skips the multiplexed address phase.
// - Keepers are off at reset and are later switched by the keeper enable bit.
// - The data lines float whenever the output float input is low.
// - In multiplexed mode two select inputs pick the control, address or data register.
// - In multiplexed mode the address strobe latches the address into the address register.
// - The ready output tells the host when the next transfer may start.
// - The subsystem select input chooses which subsystem the host reaches.
// - The dedicated host port reset resets the port and both subsystems.
// - In multiplexed mode the device interrupts the host low; writing one to the bit clears it.
module host_port_pin_interface
    import host_port_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              host_port_reset_n,
    input  wire logic              port_function_sel,
    input  wire logic              host_mux_mode_sel,
    input  wire logic              subsystem_select,
    input  wire logic              output_float_n,
    input  wire logic              keeper_enable_bit,
    input  wire logic [ADDR_W-1:0] host_addr_in,
    input  wire logic [DATA_W-1:0] host_data_in,
    input  wire logic              host_reg_sel_lo,
    input  wire logic              host_reg_sel_hi,
    input  wire logic              host_select_n,
    input  wire logic              host_strobe_one_n,
    input  wire logic              host_strobe_two_n,
    input  wire logic              host_read_not_write,
    input  wire logic              host_addr_strobe_n,
    input  wire logic              dsp_irq_set,
    input  wire logic              mem_ack,
    input  wire logic [DATA_W-1:0] mem_rdata,
    output logic      [DATA_W-1:0] host_data_out,
    output logic      [DATA_W-1:0] host_data_oe,
    output logic                   host_keep_en,
    output logic      [DATA_W-1:0] host_keep_val,
    output logic                   host_port_ready,
    output logic                   host_irq_n,
    output logic                   mem_req,
    output logic                   mem_we,
    output logic                   mem_sub,
    output logic      [ADDR_W-1:0] mem_addr,
    output logic      [DATA_W-1:0] mem_wdata,
    output logic                   subsys_reset_n
);

    // ****************************************************************
    // Reset image and decode helpers
    // ****************************************************************
    localparam port_regs_t REGS_RST = '{
        state: ST_IDLE, strobe: 1'b0, addr_strobe_n: 1'b1, keeper_on: 1'b0,
        addr: ADDR_RST, incr: 1'b0, rdata: DATA_RST, data_oe: 1'b0,
        keep_en: 1'b0, keep_val: DATA_RST, irq: 1'b0, irq_n: 1'b1,
        ready: 1'b1, mem_req: 1'b0, mem_we: 1'b0, mem_sub: 1'b0,
        mem_addr: ADDR_RST, mem_wdata: DATA_RST, sub_reset_n: 1'b0
    };

    // Both data-register codes reach RAM; only one of them steps the address.
    function automatic logic is_data_sel(input logic [1:0] sel);
        is_data_sel = (sel == SEL_DATA) || (sel == SEL_DATA_INC);
    endfunction

    port_regs_t        q;
    port_regs_t        d;
    logic              hpi_mode;
    logic              mux_mode;
    logic              strobe;
    logic              start;
    logic [1:0]        sel;
    logic [DATA_W-1:0] ctrl_word;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // All port state is computed here; the pins change one clock later.
    always_comb begin
        d         = q;
        hpi_mode  = ~port_function_sel;
        mux_mode  = ~host_mux_mode_sel;
        strobe    = hpi_mode & ~host_select_n & (~host_strobe_one_n | ~host_strobe_two_n);
        start     = strobe & ~q.strobe;
        sel       = mux_mode ? {host_reg_sel_hi, host_reg_sel_lo} : SEL_DATA;
        ctrl_word = DATA_RST;
        ctrl_word[CTRL_IRQ_BIT] = q.irq;
        d.strobe        = strobe;
        d.addr_strobe_n = host_addr_strobe_n;
        d.keeper_on     = keeper_enable_bit;
        d.sub_reset_n   = 1'b1;
        // A new interrupt in the clearing cycle survives the clear.
        d.irq = q.irq | dsp_irq_set;
        // Address strobe falling edge latches the shared lines as an address.
        if (hpi_mode && mux_mode && q.addr_strobe_n && !host_addr_strobe_n) begin
            d.addr = {2'h0, host_data_in};
        end
        unique case (q.state)
            ST_IDLE: begin
                if (start) begin
                    d.state     = ST_HOLD;
                    d.incr      = (sel == SEL_DATA_INC);
                    d.mem_sub   = subsystem_select;
                    d.mem_addr  = mux_mode ? q.addr : host_addr_in;
                    d.mem_wdata = host_data_in;
                    d.mem_we    = ~host_read_not_write;
                    if (is_data_sel(sel)) begin
                        d.mem_req = 1'b1;
                        d.state   = ST_MEM;
                    end else if (host_read_not_write) begin
                        d.rdata = (sel == SEL_ADDR) ? q.addr[DATA_W-1:0] : ctrl_word;
                    end else if (sel == SEL_ADDR) begin
                        d.addr = {2'h0, host_data_in};
                    end else if (host_data_in[CTRL_IRQ_BIT] && !dsp_irq_set) begin
                        d.irq = 1'b0;
                    end
                end
            end
            ST_MEM: begin
                if (mem_ack) begin
                    d.mem_req = 1'b0;
                    d.state   = ST_HOLD;
                    if (!q.mem_we) begin
                        d.rdata = mem_rdata;
                    end
                    if (q.incr) begin
                        d.addr = q.addr + ADDR_ONE;
                    end
                end
            end
            ST_HOLD: begin
                if (!strobe) begin
                    d.state = ST_IDLE;
                end
            end
        endcase
        // Ready only while the next transfer can be taken.
        d.ready   = (d.state == ST_IDLE) & hpi_mode;
        // Read data is driven only after it is valid, and never while floated.
        d.data_oe = hpi_mode & output_float_n & strobe & host_read_not_write
                    & (d.state == ST_HOLD);
        // The keeper sits only on a bus the device is not driving; the keeper bit is honoured after reset.
        d.keep_en = q.keeper_on & ~d.data_oe & output_float_n & hpi_mode;
        if (q.data_oe) begin
            d.keep_val = q.rdata;
        end else if (strobe && !host_read_not_write) begin
            d.keep_val = host_data_in;
        end
        d.irq_n = ~(d.irq & mux_mode);
        // The dedicated reset clears the port and holds both subsystems in reset.
        // Ready still follows the function select, so the shared pin stays quiet in memory mode.
        if (!host_port_reset_n) begin
            d       = REGS_RST;
            d.ready = hpi_mode;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Under the async reset only constants load; the strap-like inputs are sampled later.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= REGS_RST;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Every pin comes straight from the state register.
    assign host_data_out   = q.rdata;
    assign host_data_oe    = {DATA_W{q.data_oe}};
    assign host_keep_en    = q.keep_en;
    assign host_keep_val   = q.keep_val;
    assign host_port_ready = q.ready;
    assign host_irq_n      = q.irq_n;
    assign mem_req         = q.mem_req;
    assign mem_we          = q.mem_we;
    assign mem_sub         = q.mem_sub;
    assign mem_addr        = q.mem_addr;
    assign mem_wdata       = q.mem_wdata;
    assign subsys_reset_n  = q.sub_reset_n;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    emif_no_drive_a: assert property (port_function_sel |=> !host_data_oe[0] && !host_port_ready)
        else $error("host port active outside host mode");
    float_no_drive_a: assert property (!output_float_n |=> !host_data_oe[0] && !host_keep_en)
        else $error("data bus driven while floated");
    keeper_exclusive_a: assert property (host_keep_en |-> !host_data_oe[0] && $past(q.keeper_on))
        else $error("keeper fights driver");
    keeper_reset_off_a: assert property (!host_port_reset_n |=> !host_keep_en)
        else $error("keeper on during reset");
    nonmux_addr_a: assert property (host_port_ready && start && host_mux_mode_sel
        |=> mem_req && mem_addr == $past(host_addr_in))
        else $error("non-multiplexed address not used");
    addr_latch_a: assert property (host_port_reset_n && !port_function_sel && !host_mux_mode_sel
        && q.addr_strobe_n && !host_addr_strobe_n |=> q.addr[DATA_W-1:0] == $past(host_data_in))
        else $error("address strobe did not latch");
    busy_not_ready_a: assert property (mem_req |-> !host_port_ready)
        else $error("ready while memory access pending");
    read_data_a: assert property (mem_req && !mem_we && mem_ack && host_port_reset_n
        |=> host_data_out == $past(mem_rdata))
        else $error("read data not captured");
    sub_sel_a: assert property (host_port_ready && start && host_port_reset_n
        |=> mem_sub == $past(subsystem_select))
        else $error("subsystem select ignored");
    port_reset_a: assert property (!host_port_reset_n |=> !subsys_reset_n && !mem_req)
        else $error("host port reset not applied");
    irq_set_a: assert property (dsp_irq_set && host_port_reset_n && !host_mux_mode_sel
        |=> !host_irq_n)
        else $error("interrupt set lost");
    irq_nonmux_a: assert property (host_mux_mode_sel |=> host_irq_n)
        else $error("interrupt driven in non-multiplexed mode");

    read_cover_c: cover property (mem_req && !mem_we ##1 host_data_oe[0]);
    write_cover_c: cover property (mem_req && mem_we && mem_ack);
    irq_clear_cover_c: cover property (!host_irq_n ##[1:20] host_irq_n);
    keeper_cover_c: cover property (host_keep_en);

endmodule

`default_nettype wire

/* host_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Host processor side of the port
// ****************************************************************
// One transfer at a time; every qualifier is held until the port has finished with it.
module host_bus_model
    import host_port_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              host_port_ready,
    input  wire logic              mem_req,
    output logic                   host_select_n,
    output logic                   host_strobe_one_n,
    output logic                   host_strobe_two_n,
    output logic                   host_read_not_write,
    output logic      [1:0]        host_reg_sel,
    output logic                   host_addr_strobe_n,
    output logic      [ADDR_W-1:0] host_addr_in,
    output logic      [DATA_W-1:0] host_wd,
    output logic                   host_drv
);
    int unsigned n;
    // Idle pins at time zero.
    initial begin
        {host_select_n, host_strobe_one_n, host_strobe_two_n, host_addr_strobe_n} = 4'hf;
        {host_read_not_write, host_reg_sel, host_drv} = 4'h8;
        host_addr_in = ADDR_RST;
        host_wd = DATA_RST;
    end
    // Waits are bounded, so a stuck port shows up as a missing result rather than a hang.
    task automatic xfer(input logic [1:0] sel, input logic rnw, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] wd, input logic two);
        for (n = 0; n < 200 && host_port_ready !== 1'b1; n++) @(posedge clk_sys);
        host_select_n <= 1'b0;
        host_strobe_one_n <= two;
        host_strobe_two_n <= ~two;
        host_read_not_write <= rnw;
        host_reg_sel <= sel;
        host_addr_in <= a;
        host_wd <= wd;
        host_drv <= ~rnw;
        @(posedge clk_sys);
        for (n = 0; n < 4 && mem_req !== 1'b1; n++) @(posedge clk_sys);
        for (n = 0; n < 200 && mem_req === 1'b1; n++) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
        {host_select_n, host_strobe_one_n, host_strobe_two_n, host_drv} <= 4'he;
        @(posedge clk_sys);
    endtask
    // Address phase of a multiplexed host: address on the data lines, strobe low for one cycle.
    task automatic alatch(input logic [DATA_W-1:0] a);
        host_wd <= a;
        host_drv <= 1'b1;
        host_addr_strobe_n <= 1'b0;
        @(posedge clk_sys);
        host_addr_strobe_n <= 1'b1;
        @(posedge clk_sys);
        host_drv <= 1'b0;
        @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

/* host_port_pin_interface_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module host_port_pin_interface_tb_top;
    import host_port_pkg::*;
    // ****************************************************************
    // Stimulus, RAM responder and result checking
    // ****************************************************************
    logic              clk_sys, rst_n, host_port_reset_n, port_function_sel, host_mux_mode_sel;
    logic              subsystem_select, output_float_n, keeper_enable_bit, dsp_irq_set, mem_ack;
    logic              host_select_n, host_strobe_one_n, host_strobe_two_n, host_read_not_write;
    logic              host_addr_strobe_n, host_drv, host_keep_en, host_port_ready, host_irq_n;
    logic              mem_req, mem_we, mem_sub, subsys_reset_n, req_q, oe_q;
    logic [1:0]        host_reg_sel;
    logic [ADDR_W-1:0] host_addr_in, mem_addr, a;
    logic [DATA_W-1:0] host_data_in, host_data_out, host_data_oe, host_keep_val, host_wd, mem_rdata;
    logic [DATA_W-1:0] mem_wdata, noise_q, d;
    logic [DATA_W-1:0] ram [logic [ADDR_W-1:0]];
    logic [ADDR_W+1:0] exp_mem [$];
    logic [DATA_W-1:0] exp_wd [$];
    logic [DATA_W-1:0] exp_rd [$];
    int unsigned       fails, comparisons, dly;

    host_port_pin_interface host_port_pin_interface_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .host_port_reset_n(host_port_reset_n),
        .port_function_sel(port_function_sel), .host_mux_mode_sel(host_mux_mode_sel),
        .subsystem_select(subsystem_select), .output_float_n(output_float_n),
        .keeper_enable_bit(keeper_enable_bit), .host_addr_in(host_addr_in), .host_data_in(host_data_in),
        .host_reg_sel_lo(host_reg_sel[0]), .host_reg_sel_hi(host_reg_sel[1]), .host_select_n(host_select_n),
        .host_strobe_one_n(host_strobe_one_n), .host_strobe_two_n(host_strobe_two_n),
        .host_read_not_write(host_read_not_write), .host_addr_strobe_n(host_addr_strobe_n),
        .dsp_irq_set(dsp_irq_set), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .host_data_out(host_data_out),
        .host_data_oe(host_data_oe), .host_keep_en(host_keep_en), .host_keep_val(host_keep_val),
        .host_port_ready(host_port_ready), .host_irq_n(host_irq_n), .mem_req(mem_req), .mem_we(mem_we),
        .mem_sub(mem_sub), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .subsys_reset_n(subsys_reset_n));
    host_bus_model host_bus_model_inst (
        .clk_sys(clk_sys), .host_port_ready(host_port_ready), .mem_req(mem_req),
        .host_select_n(host_select_n), .host_strobe_one_n(host_strobe_one_n),
        .host_strobe_two_n(host_strobe_two_n), .host_read_not_write(host_read_not_write),
        .host_reg_sel(host_reg_sel), .host_addr_strobe_n(host_addr_strobe_n),
        .host_addr_in(host_addr_in), .host_wd(host_wd), .host_drv(host_drv));

    // A released line only holds its level through the keeper; otherwise it wanders.
    assign host_data_in = host_data_oe[0] ? host_data_out : host_drv ? host_wd : host_keep_en ? host_keep_val : noise_q;

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // RAM with a random answer delay; idle read data toggles so a stale sample is caught.
    always @(posedge clk_sys) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        noise_q <= ~host_data_in;
        if (mem_req === 1'b1 && mem_ack !== 1'b1) begin
            if (dly == 0) begin
                mem_ack <= 1'b1;
                mem_rdata <= ram.exists(mem_addr) ? ram[mem_addr] : DATA_RST;
                if (mem_we === 1'b1) ram[mem_addr] = mem_wdata;
                dly = $urandom % 4;
            end else begin
                dly--;
            end
        end
    end

    // Each new RAM request and each new read word is matched against the oldest note.
    always @(posedge clk_sys) begin
        if (mem_req === 1'b1 && req_q !== 1'b1) begin
            check("mem_cmd", 36'({mem_we, mem_sub, mem_addr}), exp_mem.size() ? 36'(exp_mem.pop_front()) : 'x);
            if (mem_we === 1'b1) check("mem_wdata", 36'(mem_wdata), exp_wd.size() ? 36'(exp_wd.pop_front()) : 'x);
        end
        if (host_data_oe[0] === 1'b1 && oe_q !== 1'b1) check("rd_data", 36'(host_data_out), exp_rd.size() ? 36'(exp_rd.pop_front()) : 'x);
        req_q <= mem_req;
        oe_q <= host_data_oe[0];
    end

    task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Notes the expected results, then has the host run the transfer.
    task automatic op(input logic [1:0] sel, input logic rnw, input logic [ADDR_W-1:0] ea,
                      input logic [DATA_W-1:0] dv, input logic two);
        if (host_mux_mode_sel === 1'b1 || sel[0]) exp_mem.push_back({~rnw, subsystem_select, ea});
        if (rnw === 1'b0 && (host_mux_mode_sel === 1'b1 || sel[0])) exp_wd.push_back(dv);
        if (rnw === 1'b1 && output_float_n === 1'b1) exp_rd.push_back(dv);
        host_bus_model_inst.xfer(sel, rnw, host_mux_mode_sel ? ea : ~ea, dv, two);
    endtask

    // Checks are made at the falling edge, where registered outputs have settled.
    task automatic look(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        #100us;
        fails++;
        tally_and_finish();
    end

    initial begin
        {rst_n, host_port_reset_n, port_function_sel, host_mux_mode_sel, subsystem_select} = 5'h08;
        {output_float_n, keeper_enable_bit, dsp_irq_set, mem_ack} = 4'h8;
        {mem_rdata, noise_q, d} = {DATA_RST, DATA_RST, DATA_RST};
        void'($urandom(32'h45d4));
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        look(2);
        check("keep_en", 36'(host_keep_en), 36'h0);
        check("irq_n", 36'(host_irq_n), 36'h1);
        check("subsys_rst", 36'(subsys_reset_n), 36'h1);
        check("ready_idle", 36'(host_port_ready), 36'h1);
        // Non-multiplexed: interrupt pulse must not reach the pin, RAM addressed from the pins.
        @(posedge clk_sys);
        host_mux_mode_sel <= 1'b1;
        dsp_irq_set <= 1'b1;
        @(posedge clk_sys);
        dsp_irq_set <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            a = ADDR_W'($urandom);
            d = DATA_W'($urandom);
            subsystem_select <= i[0];
            @(posedge clk_sys);
            op(SEL_DATA, 1'b0, a, d, i[1]);
            op(SEL_DATA, 1'b1, a, d, ~i[1]);
        end
        look(0);
        check("irq_n_nonmux", 36'(host_irq_n), 36'h1);
        // Multiplexed: latched address, auto-increment only on code 1, address read back.
        @(posedge clk_sys);
        host_mux_mode_sel <= 1'b0;
        keeper_enable_bit <= 1'b1;
        a = ADDR_W'($urandom % 32'hfff0);
        @(posedge clk_sys);
        host_bus_model_inst.alatch(a[15:0]);
        op(SEL_DATA_INC, 1'b0, a, d, 1'b0);
        op(SEL_DATA, 1'b0, a + 1, ~d, 1'b1);
        op(SEL_ADDR, 1'b1, a + 1, a[15:0] + 16'h0001, 1'b0);
        host_bus_model_inst.alatch(a[15:0]);
        op(SEL_DATA_INC, 1'b1, a, d, 1'b1);
        op(SEL_DATA, 1'b1, a + 1, ~d, 1'b0);
        look(2);
        check("keep_en", 36'(host_keep_en), 36'h1);
        check("keep_val", 36'(host_keep_val), 36'(DATA_W'(~d)));
        check("irq_n_set", 36'(host_irq_n), 36'h0);
        @(posedge clk_sys);
        op(SEL_CTRL, 1'b1, a, DATA_W'(1 << CTRL_IRQ_BIT), 1'b0);
        op(SEL_CTRL, 1'b0, a, DATA_W'(1 << CTRL_IRQ_BIT), 1'b1);
        look(0);
        check("irq_n_clr", 36'(host_irq_n), 36'h1);
        @(posedge clk_sys);
        dsp_irq_set <= 1'b1;
        @(posedge clk_sys);
        dsp_irq_set <= 1'b0;
        look(0);
        check("irq_n_again", 36'(host_irq_n), 36'h0);
        // Float: the read completes but nothing is driven and the keeper lets go.
        @(posedge clk_sys);
        output_float_n <= 1'b0;
        @(posedge clk_sys);
        op(SEL_DATA, 1'b1, a + 1, ~d, 1'b0);
        look(0);
        check("keep_en_float", 36'(host_keep_en), 36'h0);
        @(posedge clk_sys);
        output_float_n <= 1'b1;
        host_port_reset_n <= 1'b0;
        look(2);
        check("subsys_rst_low", 36'(subsys_reset_n), 36'h0);
        check("irq_n_rst", 36'(host_irq_n), 36'h1);
        @(posedge clk_sys);
        host_port_reset_n <= 1'b1;
        look(2);
        check("subsys_rst_high", 36'(subsys_reset_n), 36'h1);
        // Memory interface mode: no ready, and a strobe must not start a RAM access.
        @(posedge clk_sys);
        port_function_sel <= 1'b1;
        look(2);
        check("ready_mem_mode", 36'(host_port_ready), 36'h0);
        @(posedge clk_sys);
        host_bus_model_inst.xfer(SEL_DATA, 1'b1, a, d, 1'b0);
        look(2);
        check("mem_req_mem_mode", 36'(mem_req), 36'h0);
        // A note still queued means a RAM access or read word that never appeared.
        check("notes_left", 36'(exp_mem.size() + exp_wd.size() + exp_rd.size()), 36'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
